// file: rld_defines.svh
`ifndef RLD_DEFINES_SVH
`define RLD_DEFINES_SVH

`define RLD_PADDR_W 12
`define RLD_CTRL_OFS 12'h000
`define RLD_OFFSET_OFS 12'h004
`define RLD_HLIM_OFS 12'h008
`define RLD_LLIM_OFS 12'h00C
`define RLD_CCS_OFS 12'h010
`define RLD_STATUS_OFS 12'h014
`define RLD_MANUAL_OFS 12'h018
`define RLD_RAM_SEL 2'h1

`define RLD_CTRL_AUTO 0
`define RLD_CTRL_UDS 1
`define RLD_STAT_FRAME 0
`define RLD_STAT_LIMIT 1

`define RLD_CCS_EN 7
`define RLD_CCS_GAIN_LSB 0

`define RLD_CCS_RST 8'h21
`define RLD_HLIM_RST 6'h3F
`define RLD_LLIM_RST 6'h00
`define RLD_OFFSET_RST 6'h01
`define RLD_TICK_LAST 6'h3F

`endif

// file: rld_pkg.sv
package rld_pkg;

    typedef enum logic [1:0] {
        MODE_FIXED = 2'h0,
        MODE_STEP = 2'h1,
        MODE_UP = 2'h2,
        MODE_DOWN = 2'h3
    } rld_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_LOAD_RD,
        ST_LOAD_CAP,
        ST_RUN,
        ST_UPD
    } rld_state_t;

    typedef struct packed {
        logic [7:0] val;
        logic hit;
    } rld_upd_t;

endpackage

// file: rld_mem_if.sv
`timescale 1ns/1ns
interface rld_mem_if #(parameter int AW = 7);
    logic we;
    logic [AW-1:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface

// file: rld_ram.sv
`timescale 1ns/1ns
module rld_ram import rld_pkg::*; #(
    parameter int DEPTH = 120,
    parameter int AW = 7
) (
    input wire logic clk_i,
    rld_mem_if.mem bus
);
    logic [7:0] mem_q [DEPTH];
    logic [7:0] rdata_q;

    // Contents are not reset: software must fill the LED RAM before use
    always_ff @(posedge clk_i) begin
        if (bus.we) begin
            mem_q[bus.addr] <= bus.wdata;
        end
        rdata_q <= mem_q[bus.addr];
    end

    assign bus.rdata = rdata_q;
endmodule

// file: rld_top.sv
// Notes on behaviour
// [R1] Byte: mode in bits 7:6, duty 5:0
// [R2] Mode 00 outputs duty, never rewrites byte
// [R3] Mode 01 steps duty by offset per direction
// [R4] Mode 10 adds offset and stores back
// [R5] Mode 11 subtracts offset and stores back
// [R6] Rising breath at maximum turns mode to 11
// [R7] Falling breath at minimum turns mode to 10
// [R8] Frame done after all columns and segments
// [R9] Step mode hitting a limit signals event
// [R10] Sink conducts only when enabled and drive low
// [R11] Software writes 010 into reserved trio
// [R12] Gain select field chooses sink gain
// [R13] Control bits 3:2 read as zero
// [R14] High and low limit registers bound duty
// [R15] Auto update runs only with scan enabled
// [R16] Event pulses set sticky flags until cleared
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ns
`include "rld_defines.svh"
module rld_top import rld_pkg::*; #(
    parameter int N_MOD = 5,
    parameter int N_COM = 8
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`RLD_PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [3*N_MOD-1:0] segment_pwm_drive_o,
    output logic [3*N_MOD-1:0] current_sink_output_o,
    output logic [3*N_MOD-1:0] current_sink_output_oe_o,
    output logic [1:0] current_gain_select_o,
    output logic frame_done_irq_o,
    output logic limit_reached_irq_o
);
    localparam int NSEG = 3 * N_MOD;
    localparam int DEPTH = NSEG * N_COM;
    localparam int AW = $clog2(DEPTH);
    localparam int SW = $clog2(NSEG);
    localparam int CW = $clog2(N_COM);

    rld_mem_if #(.AW(AW)) mem_bus ();

    rld_ram #(.DEPTH(DEPTH), .AW(AW)) u_ram (
        .clk_i(clk_i),
        .bus(mem_bus)
    );

    // Register group
    logic auto_q, auto_d, uds_q, uds_d;
    logic [5:0] off_q, off_d, hlim_q, hlim_d, llim_q, llim_d;
    logic [5:0] man_q, man_d;
    logic [7:0] ccs_q, ccs_d;
    logic fflag_q, fflag_d, lflag_q, lflag_d;
    logic ready_q, ready_d, err_q, err_d, rdwait_q, rdwait_d;
    logic [31:0] rdata_q, rdata_d;

    // Engine group
    rld_state_t st_q, st_d;
    logic [SW-1:0] seg_q, seg_d;
    logic [CW-1:0] col_q, col_d;
    logic [5:0] tick_q, tick_d;
    logic [7:0] byte_q [NSEG];
    logic [7:0] byte_d [NSEG];
    logic [NSEG-1:0] drive_q, drive_d;
    logic fpulse_q, fpulse_d, lpulse_q, lpulse_d;
    logic eng_we;
    logic [AW-1:0] eng_addr;
    rld_upd_t upd;

    logic access, ram_sel, apb_use, eng_busy, wr_now;
    logic [`RLD_PADDR_W-1:0] ofs;

    function automatic rld_upd_t calc_upd(input logic [7:0] b,
        input logic [5:0] off, input logic [5:0] hl, input logic [5:0] ll,
        input logic up_sel);
        rld_upd_t r;
        logic [6:0] up;
        logic [6:0] dn;
        logic [5:0] up_s;
        logic [5:0] dn_s;
        up = {1'b0, b[5:0]} + {1'b0, off};
        dn = {1'b0, b[5:0]} - {1'b0, off};
        // Saturate at the limits so the duty never wraps
        up_s = (up >= {1'b0, hl}) ? hl : up[5:0]; // see [R14]
        dn_s = (dn[6] || dn[5:0] <= ll) ? ll : dn[5:0]; // see [R14]
        r.val = b;
        r.hit = 1'b0;
        case (rld_mode_t'(b[7:6])) // see [R1]
            MODE_FIXED: begin
                r.val = b; // see [R2]
            end
            MODE_STEP: begin
                r.val = {MODE_STEP, up_sel ? up_s : dn_s}; // see [R3]
                r.hit = up_sel ? (up_s == hl) : (dn_s == ll); // see [R9]
            end
            MODE_UP: begin
                r.val = {(up_s == hl) ? MODE_DOWN : MODE_UP, up_s}; // see [R4] [R6]
            end
            default: begin
                r.val = {(dn_s == ll) ? MODE_UP : MODE_DOWN, dn_s}; // see [R5] [R7]
            end
        endcase
        return r;
    endfunction

    assign access = psel && penable;
    assign ofs = paddr;
    assign ram_sel = (paddr[11:10] == `RLD_RAM_SEL)
        && (int'(paddr[9:2]) < DEPTH);
    assign apb_use = access && ram_sel;
    assign wr_now = access && ready_q && pwrite;
    // Engine yields the port for a whole RAM transfer, setup included
    assign eng_busy = psel && ram_sel;

    always_comb begin
        auto_d = auto_q;
        uds_d = uds_q;
        off_d = off_q;
        hlim_d = hlim_q;
        llim_d = llim_q;
        man_d = man_q;
        ccs_d = ccs_q;
        fflag_d = fflag_q;
        lflag_d = lflag_q;
        ready_d = 1'b0;
        err_d = 1'b0;
        rdwait_d = 1'b0;
        rdata_d = rdata_q;
        if (access && !ready_q) begin
            if (ram_sel && !pwrite) begin
                rdwait_d = !rdwait_q;
                ready_d = rdwait_q;
                rdata_d = {24'h000000, mem_bus.rdata};
            end else begin
                ready_d = 1'b1;
                rdata_d = 32'h00000000;
                err_d = !ram_sel;
                case (ofs)
                    `RLD_CTRL_OFS: begin
                        rdata_d[`RLD_CTRL_AUTO] = auto_q;
                        rdata_d[`RLD_CTRL_UDS] = uds_q;
                        err_d = 1'b0;
                    end
                    `RLD_OFFSET_OFS: begin
                        rdata_d[5:0] = off_q;
                        err_d = 1'b0;
                    end
                    `RLD_HLIM_OFS: begin
                        rdata_d[5:0] = hlim_q;
                        err_d = 1'b0;
                    end
                    `RLD_LLIM_OFS: begin
                        rdata_d[5:0] = llim_q;
                        err_d = 1'b0;
                    end
                    `RLD_CCS_OFS: begin
                        rdata_d[7:0] = {ccs_q[7:4], 2'h0, ccs_q[1:0]}; // see [R13]
                        err_d = 1'b0;
                    end
                    `RLD_STATUS_OFS: begin
                        rdata_d[`RLD_STAT_FRAME] = fflag_q;
                        rdata_d[`RLD_STAT_LIMIT] = lflag_q;
                        err_d = 1'b0;
                    end
                    `RLD_MANUAL_OFS: begin
                        rdata_d[5:0] = man_q;
                        err_d = 1'b0;
                    end
                    default: begin
                        rdata_d = 32'h00000000;
                    end
                endcase
            end
        end
        if (wr_now && !err_q) begin
            case (ofs)
                `RLD_CTRL_OFS: begin
                    auto_d = pwdata[`RLD_CTRL_AUTO];
                    uds_d = pwdata[`RLD_CTRL_UDS];
                end
                `RLD_OFFSET_OFS: off_d = pwdata[5:0];
                `RLD_HLIM_OFS: hlim_d = pwdata[5:0];
                `RLD_LLIM_OFS: llim_d = pwdata[5:0];
                // Reserved trio is stored as written; software keeps it 010
                `RLD_CCS_OFS: ccs_d = pwdata[7:0]; // see [R11]
                `RLD_STATUS_OFS: begin
                    fflag_d = fflag_q && !pwdata[`RLD_STAT_FRAME];
                    lflag_d = lflag_q && !pwdata[`RLD_STAT_LIMIT];
                end
                `RLD_MANUAL_OFS: man_d = pwdata[5:0];
                default: begin
                    man_d = man_q;
                end
            endcase
        end
        // Set after clear so a same-cycle event is never lost
        if (fpulse_q) begin
            fflag_d = 1'b1; // see [R16]
        end
        if (lpulse_q) begin
            lflag_d = 1'b1; // see [R16]
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            auto_q <= 1'b0;
            uds_q <= 1'b0;
            off_q <= `RLD_OFFSET_RST;
            hlim_q <= `RLD_HLIM_RST;
            llim_q <= `RLD_LLIM_RST;
            man_q <= 6'h00;
            ccs_q <= `RLD_CCS_RST;
            fflag_q <= 1'b0;
            lflag_q <= 1'b0;
            ready_q <= 1'b0;
            err_q <= 1'b0;
            rdwait_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            auto_q <= auto_d;
            uds_q <= uds_d;
            off_q <= off_d;
            hlim_q <= hlim_d;
            llim_q <= llim_d;
            man_q <= man_d;
            ccs_q <= ccs_d;
            fflag_q <= fflag_d;
            lflag_q <= lflag_d;
            ready_q <= ready_d;
            err_q <= err_d;
            rdwait_q <= rdwait_d;
            rdata_q <= rdata_d;
        end
    end

    assign pready = ready_q;
    assign pslverr = ready_q && err_q;
    assign prdata = rdata_q;

    assign eng_addr = AW'(int'(col_q) * NSEG + int'(seg_q));
    assign upd = calc_upd(byte_q[seg_q], off_q, hlim_q, llim_q, uds_q);

    always_comb begin
        st_d = st_q;
        seg_d = seg_q;
        col_d = col_q;
        tick_d = tick_q + 6'h01;
        byte_d = byte_q;
        fpulse_d = 1'b0;
        lpulse_d = 1'b0;
        eng_we = 1'b0;
        case (st_q)
            ST_IDLE: begin
                seg_d = '0;
                col_d = '0;
                if (auto_q) begin
                    st_d = ST_LOAD_RD; // see [R15]
                end
            end
            ST_LOAD_RD: begin
                if (!auto_q) begin
                    st_d = ST_IDLE;
                end else if (!eng_busy) begin
                    st_d = ST_LOAD_CAP;
                end
            end
            ST_LOAD_CAP: begin
                byte_d[seg_q] = mem_bus.rdata;
                // Leave at once so no period starts after auto goes off
                if (!auto_q) begin
                    st_d = ST_IDLE; // see [R15]
                end else if (seg_q == SW'(NSEG - 1)) begin
                    seg_d = '0;
                    tick_d = 6'h00;
                    st_d = ST_RUN;
                end else begin
                    seg_d = seg_q + SW'(1);
                    st_d = ST_LOAD_RD;
                end
            end
            ST_RUN: begin
                if (!auto_q) begin
                    st_d = ST_IDLE;
                end else if (tick_q == `RLD_TICK_LAST) begin
                    st_d = ST_UPD;
                end
            end
            ST_UPD: begin
                if (!auto_q) begin
                    st_d = ST_IDLE;
                end else if (!eng_busy) begin
                    // Write-back happens after the period is output
                    eng_we = byte_q[seg_q][7:6] != MODE_FIXED; // see [R2] [R3]
                    lpulse_d = upd.hit; // see [R9]
                    st_d = ST_LOAD_RD;
                    if (seg_q == SW'(NSEG - 1)) begin
                        seg_d = '0;
                        if (col_q == CW'(N_COM - 1)) begin
                            col_d = '0;
                            fpulse_d = 1'b1; // see [R8]
                        end else begin
                            col_d = col_q + CW'(1);
                        end
                    end else begin
                        seg_d = seg_q + SW'(1);
                        st_d = ST_UPD;
                    end
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    for (genvar i = 0; i < NSEG; i++) begin : g_seg
        // Drive low means the sink conducts; off between periods
        always_comb begin
            if (st_q == ST_RUN) begin
                drive_d[i] = !(tick_q < byte_q[i][5:0]); // see [R1]
            end else if (!auto_q) begin
                drive_d[i] = !(tick_q < man_q); // see [R15]
            end else begin
                drive_d[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_q <= ST_IDLE;
            seg_q <= '0;
            col_q <= '0;
            tick_q <= 6'h00;
            byte_q <= '{default: 8'h00};
            drive_q <= '1;
            fpulse_q <= 1'b0;
            lpulse_q <= 1'b0;
        end else begin
            st_q <= st_d;
            seg_q <= seg_d;
            col_q <= col_d;
            tick_q <= tick_d;
            byte_q <= byte_d;
            drive_q <= drive_d;
            fpulse_q <= fpulse_d;
            lpulse_q <= lpulse_d;
        end
    end

    assign mem_bus.addr = apb_use ? paddr[2+:AW] : eng_addr;
    assign mem_bus.we = apb_use ? wr_now : eng_we;
    assign mem_bus.wdata = apb_use ? pwdata[7:0] : upd.val;

    assign segment_pwm_drive_o = drive_q;
    assign current_sink_output_o = '0;
    assign current_sink_output_oe_o =
        {NSEG{ccs_q[`RLD_CCS_EN]}} & ~drive_q; // see [R10]
    assign current_gain_select_o = ccs_q[`RLD_CCS_GAIN_LSB+:2]; // see [R12]
    assign frame_done_irq_o = fpulse_q;
    assign limit_reached_irq_o = lpulse_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    sequence s_eng_write;
        st_q == ST_UPD && eng_we;
    endsequence

    a_frame_flag_set: assert property ( // see [R8] [R16]
        frame_done_irq_o |=> fflag_q)
        else $error("frame flag not set after frame pulse");
    a_flag_sticky: assert property ( // see [R16]
        lflag_q && !(wr_now && ofs == `RLD_STATUS_OFS) |=> lflag_q)
        else $error("limit flag dropped without clear");
    a_sink_gated: assert property ( // see [R10]
        !ccs_q[`RLD_CCS_EN] |-> current_sink_output_oe_o == '0)
        else $error("sink driven while disabled");
    a_ccs_gap_zero: assert property ( // see [R13]
        pready && !pwrite && paddr == `RLD_CCS_OFS |-> prdata[3:2] == 2'h0)
        else $error("unimplemented bits read nonzero");
    a_fixed_no_write: assert property ( // see [R2]
        st_q == ST_UPD && auto_q && !eng_busy
        && byte_q[seg_q][7:6] == MODE_FIXED |-> !mem_bus.we)
        else $error("fixed mode byte rewritten");
    a_breath_turn_up: assert property ( // see [R6]
        s_eng_write ##0 (byte_q[seg_q][7:6] == MODE_UP
        && mem_bus.wdata[5:0] == hlim_q) |-> mem_bus.wdata[7:6] == MODE_DOWN)
        else $error("breathing did not turn down at maximum");
    a_breath_turn_dn: assert property ( // see [R7]
        s_eng_write ##0 (byte_q[seg_q][7:6] == MODE_DOWN
        && mem_bus.wdata[5:0] == llim_q) |-> mem_bus.wdata[7:6] == MODE_UP)
        else $error("breathing did not turn up at minimum");
    a_auto_off_quiet: assert property ( // see [R15]
        !auto_q |-> !eng_we ##1 (st_q == ST_IDLE))
        else $error("auto update active while disabled");
    a_limit_cause: assert property ( // see [R9]
        limit_reached_irq_o |-> $past(st_q) == ST_UPD
        && $past(byte_q[seg_q][7:6]) == MODE_STEP)
        else $error("limit event outside step mode");
    a_gain_follow: assert property ( // see [R12]
        wr_now && !err_q && ofs == `RLD_CCS_OFS
        |=> current_gain_select_o == $past(pwdata[1:0]))
        else $error("gain select did not follow write");
    a_run_hold: assert property ( // see [R1]
        $rose(st_q == ST_RUN) && auto_q |-> (st_q == ST_RUN)[*8])
        else $error("pwm period cut short");
endmodule

// file: rld_led_model.sv
`timescale 1ns/1ns
module rld_led_model #(
    parameter int NSEG = 3
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [NSEG-1:0] current_sink_output_i,
    input wire logic [NSEG-1:0] current_sink_output_oe_i,
    output logic [15:0] lit_cnt_o [NSEG]
);
    // The anode supply pulls a released sink line high, so a floating
    // output never shows the last level that was driven
    logic [NSEG-1:0] line_lvl;

    assign line_lvl = (current_sink_output_oe_i & current_sink_output_i)
        | ~current_sink_output_oe_i;

    // Lit time per segment, counted in clock cycles
    always_ff @(posedge clk_i) begin
        for (int s = 0; s < NSEG; s++) begin
            if (reset_i) begin
                lit_cnt_o[s] <= 16'h0000;
            end else if (line_lvl[s] === 1'b0) begin
                lit_cnt_o[s] <= lit_cnt_o[s] + 16'h0001;
            end
        end
    end
endmodule

// file: tb.sv
`timescale 1ns/1ns
`include "rld_defines.svh"
module tb;
    // Small matrix keeps one frame near 146 cycles
    localparam int NM = 1;
    localparam int NC = 2;
    localparam int NS = 3 * NM;
    logic clk_i, reset_i, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [NS-1:0] drive, sink, sink_oe;
    logic [1:0] gain;
    logic frame_irq, lim_irq;
    logic [15:0] lit [NS];
    logic [15:0] lit0;
    logic [11:0] ra;
    logic [32:0] exp_q [$];
    logic [7:0] ram_init [6] = '{8'h10, 8'h45, 8'hBD, 8'hC2, 8'h7E, 8'h00};
    logic [7:0] ram_exp [6] = '{8'h10, 8'h47, 8'hFF, 8'h80, 8'h7F, 8'h00};
    logic [7:0] ram_dn [6] = '{8'h10, 8'h45, 8'hFD, 8'h82, 8'h7D, 8'h00};
    logic [15:0] lit_exp [NS] = '{16'h0012, 16'h0043, 16'h003D};
    int bad_count, checks_done, frame_cnt, lim_cnt, n;

    rld_top #(.N_MOD(NM), .N_COM(NC)) u_dut (
        .clk_i(clk_i), .reset_i(reset_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .segment_pwm_drive_o(drive), .current_sink_output_o(sink),
        .current_sink_output_oe_o(sink_oe), .current_gain_select_o(gain),
        .frame_done_irq_o(frame_irq), .limit_reached_irq_o(lim_irq)
    );

    rld_led_model #(.NSEG(NS)) u_leds (
        .clk_i(clk_i), .reset_i(reset_i), .current_sink_output_i(sink),
        .current_sink_output_oe_i(sink_oe), .lit_cnt_o(lit)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic check_bus(input logic [32:0] e, input logic [32:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic check_val(input logic [15:0] g, input logic [15:0] e);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Master holds the whole request until pready is seen high
    task automatic apb(input logic wr, input logic [11:0] a,
            input logic [31:0] d, input logic [32:0] e);
        int k;
        @(posedge clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        exp_q.push_back(e);
        @(posedge clk_i);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            bad_count++;
            $display("unexpected at %0t: expected %h got %h", $time, 1'b1,
                pready);
            conclude();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask

    task automatic reg_rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e});
    endtask

    // Waits for the next frame pulse; a missing one ends the run
    task automatic wait_frame;
        int want;
        want = frame_cnt + 1;
        n = 0;
        while (frame_cnt < want && n < 3000) begin
            @(posedge clk_i);
            n++;
        end
        check_val(16'(n < 3000), 16'h0001);
        if (n >= 3000) begin
            conclude();
        end
    endtask

    // Result watcher: every finished transfer takes the oldest note
    always @(posedge clk_i) begin
        if (frame_irq === 1'b1) begin
            frame_cnt++;
        end
        if (lim_irq === 1'b1) begin
            lim_cnt++;
        end
        if (psel && penable && pready === 1'b1) begin
            check_bus(exp_q.size() > 0 ? exp_q.pop_front() : 33'hx,
                {pslverr, pwrite ? 32'h0 : prdata});
        end
    end

    initial begin
        reset_i = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        void'($urandom(18));
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        check_val({14'h0, gain}, 16'h0001);
        reg_rd(`RLD_CCS_OFS, 32'h21);
        reg_rd(`RLD_HLIM_OFS, 32'h3F);
        reg_rd(`RLD_LLIM_OFS, 32'h00);
        reg_rd(`RLD_OFFSET_OFS, 32'h01);
        $display("test reset values done");
        for (int g = 0; g < 4; g++) begin
            reg_wr(`RLD_CCS_OFS, 32'h20 | g);
            @(negedge clk_i);
            check_val({14'h0, gain}, 16'(g));
            reg_rd(`RLD_CCS_OFS, 32'h20 | g);
        end
        // Enable also stays set for the frame test below
        reg_wr(`RLD_CCS_OFS, 32'hAF);
        reg_rd(`RLD_CCS_OFS, 32'hA3);
        apb(1'b0, 12'h418, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 12'h020, 32'h5A, {1'b1, 32'h0});
        repeat (4) begin
            r = $urandom;
            reg_wr(`RLD_LLIM_OFS, r);
            reg_rd(`RLD_LLIM_OFS, r & 32'h3F);
        end
        reg_wr(`RLD_LLIM_OFS, 32'h0);
        $display("test register access done");
        reg_wr(`RLD_OFFSET_OFS, 32'h02);
        for (int i = 0; i < 6; i++) begin
            ra = 12'(12'h400 + 4 * i);
            reg_wr(ra, {24'h0, ram_init[i]});
        end
        reg_wr(`RLD_CTRL_OFS, 32'h3);
        wait_frame();
        for (int s = 0; s < NS; s++) begin
            check_val(lit[s], lit_exp[s]);
        end
        // Off before the next frame reaches any write-back
        reg_wr(`RLD_CTRL_OFS, 32'h0);
        check_val(16'(lim_cnt), 16'h0001);
        for (int i = 0; i < 6; i++) begin
            ra = 12'(12'h400 + 4 * i);
            r = {24'h0, ram_exp[i]};
            reg_rd(ra, r);
        end
        $display("test auto frame done");
        repeat (200) @(posedge clk_i);
        reg_rd(12'h404, 32'h47);
        check_val(16'(frame_cnt), 16'h0001);
        // Free-running tick: any 64 cycles hold exactly duty low cycles
        reg_wr(`RLD_MANUAL_OFS, 32'h15);
        reg_rd(`RLD_MANUAL_OFS, 32'h15);
        lit0 = lit[0];
        n = 0;
        repeat (64) begin
            @(posedge clk_i);
            n += int'(drive[1] === 1'b0);
        end
        check_val(16'(n), 16'h0015);
        check_val(lit[0] - lit0, 16'h0015);
        $display("test manual duty done");
        reg_rd(`RLD_STATUS_OFS, 32'h3);
        reg_wr(`RLD_STATUS_OFS, 32'h3);
        reg_rd(`RLD_STATUS_OFS, 32'h0);
        $display("test flags done");
        // Second frame counts down; nothing reaches a limit this time
        reg_wr(`RLD_CTRL_OFS, 32'h1);
        wait_frame();
        reg_wr(`RLD_CTRL_OFS, 32'h0);
        for (int i = 0; i < 6; i++) begin
            ra = 12'(12'h400 + 4 * i);
            r = {24'h0, ram_dn[i]};
            reg_rd(ra, r);
        end
        reg_rd(`RLD_STATUS_OFS, 32'h1);
        check_val(16'(lim_cnt), 16'h0001);
        $display("test step down done");
        conclude();
    end
endmodule
